// ==== inc/irq_mask_pkg.sv ====
// package: register map, field layout and carriers of the event mask block
`default_nettype none
package irq_mask_pkg;
   // register offsets
   localparam logic [15:0] EVENT_INTERRUPT_ENABLE_ZERO_ADDR = 16'hE50A;
   localparam logic [15:0] EVENT_STATUS_ZERO_ADDR          = 16'hE5F0;
   localparam logic [15:0] ACCUMULATION_MODE_ADDR          = 16'hE5F1;
   localparam logic [15:0] PULSE_OUTPUT_MODE_ADDR          = 16'hE5F2;
   localparam logic [15:0] HARMONIC_CONFIG_ADDR            = 16'hE5F3;
   localparam logic [15:0] HALF_LINE_CYCLE_COUNT_ADDR      = 16'hE5F4;

   // event bit positions, shared by status and mask
   localparam int TOTAL_ACTIVE_HF_BIT   = 0;
   localparam int FUND_ACTIVE_HF_BIT    = 1;
   localparam int FUND_REACTIVE_HF_BIT  = 3;
   localparam int APPARENT_HF_BIT       = 4;
   localparam int LINE_CYCLE_DONE_BIT   = 5;
   localparam int ACTIVE_SIGN_LSB       = 6;
   localparam int PATH_ONE_SUM_BIT      = 9;
   localparam int REACTIVE_SIGN_LSB     = 10;
   localparam int PATH_TWO_SUM_BIT      = 13;
   localparam int PULSE_FALL_LSB        = 14;
   localparam int RESET_COMPLETE_BIT    = 15;
   localparam int DSP_CYCLE_DONE_BIT    = 17;
   localparam int PATH_THREE_SUM_BIT    = 18;
   localparam int HARMONIC_UPDATE_BIT   = 19;

   // implemented mask bits; bit 2, bit 15 and bits 31:20 steer nothing
   localparam logic [31:0] MASK_STORED  = 32'h000F_FFFF;
   localparam logic [31:0] MASK_EFFECT  = 32'h000F_7FFB;
   localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
   localparam logic [31:0] STATUS_RESET = 32'h0000_8000;

   // configuration fields
   localparam int ACTIVE_SIGN_SOURCE_BIT = 6;
   localparam int LINE_CYCLE_MODE_BIT    = 0;
   localparam int PULSE_DISABLE_LSB      = 9;
   localparam int HARMONIC_NO_SETTLE_BIT = 1;
   localparam int HARMONIC_SETTLE_LSB    = 3;
   localparam int HARMONIC_RATE_LSB      = 5;
   localparam logic [7:0]  ACCUMULATION_MODE_RESET = 8'h00;
   localparam logic [11:0] PULSE_OUTPUT_MODE_RESET = 12'h000;
   localparam logic [7:0]  HARMONIC_CONFIG_RESET   = 8'h00;
   localparam logic [15:0] HALF_LINE_CYCLE_RESET   = 16'h0000;

   // timing
   localparam int CLK_MHZ         = 100;
   localparam int SETTLE_UNIT_MS  = 1;
   localparam int SETTLE_UNIT_CYC = SETTLE_UNIT_MS * CLK_MHZ * 1000;

   typedef struct packed {
      logic [2:0] total_active;
      logic [2:0] fund_active;
      logic [2:0] fund_reactive;
      logic [2:0] apparent;
   } energy_bit30_t;

   typedef struct packed {
      logic [2:0] total_active;
      logic [2:0] fund_active;
      logic [2:0] fund_reactive;
      logic [2:0] path_sum;
   } power_sign_t;

   typedef struct packed {
      logic       line_cycle_done;
      logic       dsp_cycle_done;
      logic       harmonic_setup;
      logic       harmonic_update;
      logic       normal_mode_entry;
   } engine_pulse_t;
endpackage : irq_mask_pkg
`default_nettype wire

// ==== hdl/energy_event_irq_mask_zero.sv ====
// interrupt status, enable mask and request line for the metering events
//
// Overview of operation
// - mask bit 0 enables interrupt on bit 30 toggle of total active energy
// - mask bit 1 enables interrupt on bit 30 toggle of fundamental active
// - mask bit 2 never affects interrupt generation
// - mask bit 3 enables interrupt on bit 30 toggle of fundamental reactive
// - mask bit 4 enables interrupt on bit 30 toggle of apparent energy
// - mask bit 5 enables line-cycle completion interrupt in line-cycle mode
// - mask bits 6-8 enable per-phase active power sign change interrupts
// - mask bits 9, 13, 18 enable pulse-path power sum sign change interrupts
// - mask bits 10-12 enable per-phase fundamental reactive sign interrupts
// - mask bits 14 and 16 enable interrupts on pulse output one and three falling edges
// - pulse interrupts still occur while the pulse pin is disabled
// - mask bit 17 enables interrupt when the periodic DSP cycle completes
// - mask bit 19 enables harmonic update interrupts after settling delay
// - with no-settle bit set, harmonic interrupts start right after setup
// - mask bits above 19 are reserved and do nothing
// - reset-complete always pulls the request line low, mask ignored
//
// Local design decision: strobed register access.
`default_nettype none
module energy_event_irq_mask_zero
   import irq_mask_pkg::*;
#(
   parameter int SETTLE_UNIT_CYCLES = SETTLE_UNIT_CYC
) (
   // clock and reset
   input  wire logic          CLK,
   input  wire logic          SRST,
   // register port
   input  wire logic [15:0]   ADDR,
   input  wire logic [31:0]   WDATA,
   input  wire logic          WR,
   input  wire logic          RD,
   output logic      [31:0]   RDATA,
   // event sources
   input  wire energy_bit30_t ENERGY_BIT30,
   input  wire power_sign_t   POWER_SIGN,
   input  wire engine_pulse_t ENGINE_PULSE,
   input  wire logic [2:0]    PULSE_LEVEL,
   // pulse pins and configuration to the datapath
   output logic      [2:0]    PULSE_OUTPUT_N,
   output logic      [8:0]    PULSE_SOURCE_SELECT,
   output logic      [15:0]   HALF_LINE_CYCLES,
   output logic      [2:0]    HARMONIC_RATE,
   output logic               LINE_CYCLE_MODE,
   // interrupt
   output logic               INTERRUPT_REQUEST_ONE_N
);

   logic [31:0]   mask_r;
   logic [31:0]   status_r;
   logic [31:0]   status_nxt;
   logic [31:0]   events;
   logic [31:0]   rdata_nxt;
   logic [7:0]    acc_mode_r;
   logic [11:0]   pulse_mode_r;
   logic [7:0]    harm_cfg_r;
   logic [15:0]   half_cycles_r;
   energy_bit30_t bit30_prev_r;
   power_sign_t   sign_prev_r;
   logic [2:0]    pulse_prev_r;
   logic          primed_r;
   logic [2:0]    active_sign;
   logic [2:0]    active_sign_prev;
   logic [23:0]   settle_cnt_r;
   logic          settled_r;
   logic          harm_event;
   logic          irq_n_nxt;

   // register map seen by software; narrow registers read zero above:
   //    event_interrupt_enable_zero  32 bits, bits 19:0 kept
   //    event status                 32 bits, cleared by a read
   //    accumulation_mode             8 bits
   //    pulse_output_mode            12 bits, selects 8:0, disables 11:9
   //    harmonic_config               8 bits
   //    half_line_cycle_count        16 bits
   // offsets are the package's address constants
   // unmapped reads return zero and unmapped writes are dropped

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge CLK) begin
      if (SRST) begin
         mask_r <= MASK_RESET;
      end else if (WR && ADDR == EVENT_INTERRUPT_ENABLE_ZERO_ADDR) begin
         // reserved upper bits are dropped so they read back as zero
         mask_r <= WDATA & MASK_STORED;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         acc_mode_r <= ACCUMULATION_MODE_RESET;
      end else if (WR && ADDR == ACCUMULATION_MODE_ADDR) begin
         acc_mode_r <= WDATA[7:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         pulse_mode_r <= PULSE_OUTPUT_MODE_RESET;
      end else if (WR && ADDR == PULSE_OUTPUT_MODE_ADDR) begin
         pulse_mode_r <= WDATA[11:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         harm_cfg_r <= HARMONIC_CONFIG_RESET;
      end else if (WR && ADDR == HARMONIC_CONFIG_ADDR) begin
         harm_cfg_r <= WDATA[7:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         half_cycles_r <= HALF_LINE_CYCLE_RESET;
      end else if (WR && ADDR == HALF_LINE_CYCLE_COUNT_ADDR) begin
         half_cycles_r <= WDATA[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // previous samples for edge and toggle detection
   always_ff @(posedge CLK) begin
      if (SRST) begin
         bit30_prev_r <= '0;
      end else begin
         bit30_prev_r <= ENERGY_BIT30;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         sign_prev_r <= '0;
      end else begin
         sign_prev_r <= POWER_SIGN;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         pulse_prev_r <= 3'h7;
      end else begin
         pulse_prev_r <= PULSE_LEVEL;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         primed_r <= 1'b0;
      end else begin
         // first sample after reset only seeds the history
         primed_r <= 1'b1;
      end
   end

   // selected active power flavour per phase
   always_comb begin
      if (acc_mode_r[ACTIVE_SIGN_SOURCE_BIT]) begin
         active_sign      = POWER_SIGN.fund_active;
         active_sign_prev = sign_prev_r.fund_active;
      end else begin
         active_sign      = POWER_SIGN.total_active;
         active_sign_prev = sign_prev_r.total_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // harmonic settling timer, restarted by every harmonic setup
   always_ff @(posedge CLK) begin
      if (SRST) begin
         settle_cnt_r <= 24'h00_0000;
      end else if (ENGINE_PULSE.harmonic_setup) begin
         // settle time grows in whole units with the field value
         settle_cnt_r <= 24'(SETTLE_UNIT_CYCLES *
            (int'(harm_cfg_r[HARMONIC_SETTLE_LSB +: 2]) + 1));
      end else if (settle_cnt_r != 24'h00_0000) begin
         settle_cnt_r <= settle_cnt_r - 24'h00_0001;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         settled_r <= 1'b0;
      end else if (ENGINE_PULSE.harmonic_setup) begin
         settled_r <= harm_cfg_r[HARMONIC_NO_SETTLE_BIT];
      end else if (settle_cnt_r == 24'h00_0001) begin
         // stays set until the next setup restarts the wait
         settled_r <= 1'b1;
      end
   end

   always_comb begin
      harm_event = ENGINE_PULSE.harmonic_update &&
         (settled_r || harm_cfg_r[HARMONIC_NO_SETTLE_BIT]);
   end

   // status and mask share one layout:
   //    0  total active energy bit 30 toggle
   //    1  fundamental active energy bit 30 toggle
   //    2  unused
   //    3  fundamental reactive energy bit 30 toggle
   //    4  apparent energy bit 30 toggle
   //    5  line-cycle accumulation done
   //    6  phase A active power sign change
   //    7  phase B active power sign change
   //    8  phase C active power sign change
   //    9  pulse path one summed power sign change
   //   10  phase A fundamental reactive sign change
   //   11  phase B fundamental reactive sign change
   //   12  phase C fundamental reactive sign change
   //   13  pulse path two summed power sign change
   //   14  pulse output one falling edge
   //   15  pulse output two falling edge, or reset complete
   //   16  pulse output three falling edge
   //   17  signal-processing cycle done
   //   18  pulse path three summed power sign change
   //   19  harmonic results updated
   //   31:20 unused, read as zero
   // status bit 15 cannot be masked, so pulse output two is unmaskable

   ////////////////////////////////////////////////////////////////////////////
   // event vector in status layout
   always_comb begin
      events = 32'h0000_0000;
      // toggles need an earlier sample, so the first cycle is skipped
      if (primed_r) begin
         events[TOTAL_ACTIVE_HF_BIT]  =
            |(ENERGY_BIT30.total_active ^ bit30_prev_r.total_active);
         events[FUND_ACTIVE_HF_BIT]   =
            |(ENERGY_BIT30.fund_active ^ bit30_prev_r.fund_active);
         events[FUND_REACTIVE_HF_BIT] =
            |(ENERGY_BIT30.fund_reactive ^ bit30_prev_r.fund_reactive);
         events[APPARENT_HF_BIT]      =
            |(ENERGY_BIT30.apparent ^ bit30_prev_r.apparent);
         events[ACTIVE_SIGN_LSB +: 3] = active_sign ^ active_sign_prev;
         events[REACTIVE_SIGN_LSB +: 3] =
            POWER_SIGN.fund_reactive ^ sign_prev_r.fund_reactive;
         events[PATH_ONE_SUM_BIT]     =
            POWER_SIGN.path_sum[0] ^ sign_prev_r.path_sum[0];
         events[PATH_TWO_SUM_BIT]     =
            POWER_SIGN.path_sum[1] ^ sign_prev_r.path_sum[1];
         events[PATH_THREE_SUM_BIT]   =
            POWER_SIGN.path_sum[2] ^ sign_prev_r.path_sum[2];
         // taken from the internal level, so a disabled pin still counts
         events[PULSE_FALL_LSB +: 3]  = pulse_prev_r & ~PULSE_LEVEL;
      end
      events[LINE_CYCLE_DONE_BIT] = ENGINE_PULSE.line_cycle_done &&
         acc_mode_r[LINE_CYCLE_MODE_BIT];
      events[DSP_CYCLE_DONE_BIT]  = ENGINE_PULSE.dsp_cycle_done;
      events[HARMONIC_UPDATE_BIT] = harm_event;
      // pulse two fall and reset-complete share bit 15, so both feed it
      events[RESET_COMPLETE_BIT]  = events[RESET_COMPLETE_BIT] |
         ENGINE_PULSE.normal_mode_entry;
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky status, cleared by a read; a new event beats the clear
   always_comb begin
      status_nxt = status_r;
      if (RD && ADDR == EVENT_STATUS_ZERO_ADDR) begin
         status_nxt = 32'h0000_0000;
      end
      status_nxt = status_nxt | events;
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         // reset-complete comes up set, so the line drops after release
         status_r <= STATUS_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   // bits 2 and 15 of the mask and all reserved bits are ignored here
   always_comb begin
      irq_n_nxt = ~(|(status_r & mask_r & MASK_EFFECT)
         | status_r[RESET_COMPLETE_BIT]);
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         INTERRUPT_REQUEST_ONE_N <= 1'b1;
      end else begin
         INTERRUPT_REQUEST_ONE_N <= irq_n_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe, zero otherwise
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (RD) begin
         unique case (ADDR)
            EVENT_INTERRUPT_ENABLE_ZERO_ADDR: begin
               rdata_nxt = mask_r;
            end
            EVENT_STATUS_ZERO_ADDR: begin
               // flags as they stood before the read clears them
               rdata_nxt = status_r;
            end
            ACCUMULATION_MODE_ADDR: begin
               rdata_nxt = {24'h00_0000, acc_mode_r};
            end
            PULSE_OUTPUT_MODE_ADDR: begin
               rdata_nxt = {20'h0_0000, pulse_mode_r};
            end
            HARMONIC_CONFIG_ADDR: begin
               rdata_nxt = {24'h00_0000, harm_cfg_r};
            end
            HALF_LINE_CYCLE_COUNT_ADDR: begin
               rdata_nxt = {16'h0000, half_cycles_r};
            end
            default:                    rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         RDATA <= 32'h0000_0000;
      end else begin
         RDATA <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins and configuration outputs
   always_ff @(posedge CLK) begin
      if (SRST) begin
         PULSE_OUTPUT_N <= 3'h7;
      end else begin
         // a disabled pin idles high; the interrupt path is unaffected
         PULSE_OUTPUT_N <= PULSE_LEVEL |
            pulse_mode_r[PULSE_DISABLE_LSB +: 3];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         PULSE_SOURCE_SELECT <= 9'h000;
      end else begin
         PULSE_SOURCE_SELECT <= pulse_mode_r[8:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         HALF_LINE_CYCLES <= HALF_LINE_CYCLE_RESET;
      end else begin
         HALF_LINE_CYCLES <= half_cycles_r;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         HARMONIC_RATE <= 3'h0;
      end else begin
         HARMONIC_RATE <= harm_cfg_r[HARMONIC_RATE_LSB +: 3];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         LINE_CYCLE_MODE <= 1'b0;
      end else begin
         LINE_CYCLE_MODE <= acc_mode_r[LINE_CYCLE_MODE_BIT];
      end
   end

endmodule : energy_event_irq_mask_zero
`default_nettype wire

// ==== verification/irq_mask_asserts.sv ====
// checker: timing of the request line against events and bus accesses
`default_nettype none
module irq_mask_asserts
   import irq_mask_pkg::*;
#(
   parameter int SETTLE_UNIT_CYCLES = 4
) (
   // clock, reset and register port
   input wire logic          CLK,
   input wire logic          SRST,
   input wire logic [15:0]   ADDR,
   input wire logic [31:0]   WDATA,
   input wire logic          WR,
   input wire logic          RD,
   input wire logic [31:0]   RDATA,
   // events and request line
   input wire energy_bit30_t ENERGY_BIT30,
   input wire power_sign_t   POWER_SIGN,
   input wire engine_pulse_t ENGINE_PULSE,
   input wire logic [2:0]    PULSE_LEVEL,
   input wire logic          LINE_CYCLE_MODE,
   input wire logic          INTERRUPT_REQUEST_ONE_N
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mask_r;
   logic        no_settle_r;
   logic [2:0]  access_r;
   // shadow of the mask as software wrote it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         mask_r      <= MASK_RESET;
         no_settle_r <= 1'b0;
         access_r    <= 3'h0;
      end else begin
         access_r <= {access_r[1:0], RD | WR};
         if (WR && ADDR == EVENT_INTERRUPT_ENABLE_ZERO_ADDR)
            mask_r <= WDATA & MASK_STORED;
         if (WR && ADDR == HARMONIC_CONFIG_ADDR)
            no_settle_r <= WDATA[HARMONIC_NO_SETTLE_BIT];
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence s_irq_low;
      ##[1:3] !INTERRUPT_REQUEST_ONE_N;
   endsequence
   sequence s_recent_access;
      |access_r;
   endsequence
   a_reset_done_line: assert property (
      $fell(SRST) |-> ##[1:2] !INTERRUPT_REQUEST_ONE_N)
      else $error("request line not low after reset");
   a_normal_entry_irq: assert property (
      ENGINE_PULSE.normal_mode_entry |-> s_irq_low)
      else $error("reset complete did not interrupt");
   a_total_energy_irq: assert property (
      $changed(ENERGY_BIT30.total_active) && mask_r[0] |-> s_irq_low)
      else $error("total energy toggle missed");
   a_apparent_irq: assert property (
      $changed(ENERGY_BIT30.apparent) && mask_r[4] |-> s_irq_low)
      else $error("apparent energy toggle missed");
   a_pulse_fall_irq: assert property (
      $fell(PULSE_LEVEL[0]) && mask_r[14] |-> s_irq_low)
      else $error("pulse falling edge missed");
   a_path_sign_irq: assert property (
      $changed(POWER_SIGN.path_sum[0]) && mask_r[9] |-> s_irq_low)
      else $error("path sum sign change missed");
   a_dsp_done_irq: assert property (
      ENGINE_PULSE.dsp_cycle_done && mask_r[17] |-> s_irq_low)
      else $error("dsp completion missed");
   a_line_cycle_irq: assert property (
      ENGINE_PULSE.line_cycle_done && LINE_CYCLE_MODE && mask_r[5]
      |-> s_irq_low)
      else $error("line cycle completion missed");
   a_no_settle_irq: assert property (
      ENGINE_PULSE.harmonic_update && no_settle_r && mask_r[19]
      |-> s_irq_low)
      else $error("harmonic update missed");
   a_mask_upper_zero: assert property (
      RD && ADDR == EVENT_INTERRUPT_ENABLE_ZERO_ADDR |=> RDATA[31:20] == 0)
      else $error("reserved mask bits read back");
   a_irq_release_cause: assert property (
      $rose(INTERRUPT_REQUEST_ONE_N) |-> s_recent_access)
      else $error("request released without access");
endmodule : irq_mask_asserts
bind energy_event_irq_mask_zero irq_mask_asserts #(
   .SETTLE_UNIT_CYCLES(SETTLE_UNIT_CYCLES)) i_chk (
   .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .ENERGY_BIT30(ENERGY_BIT30),
   .POWER_SIGN(POWER_SIGN), .ENGINE_PULSE(ENGINE_PULSE),
   .PULSE_LEVEL(PULSE_LEVEL), .LINE_CYCLE_MODE(LINE_CYCLE_MODE),
   .INTERRUPT_REQUEST_ONE_N(INTERRUPT_REQUEST_ONE_N));
`default_nettype wire

// ==== verification/irq_host_model.sv ====
// host model: register port master of the microcontroller
`default_nettype none
module irq_host_model (
   // register port
   input  wire logic        clk,
   output var  logic [15:0] addr,
   output var  logic [31:0] wdata,
   output var  logic        wr,
   output var  logic        rd,
   input  wire logic [31:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr  = 16'h0000;
      wdata = 32'h0000_0000;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   task automatic write_reg(input logic [15:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      // stale data is not left on the bus
      wdata <= ~d;
      @(posedge clk);
   endtask : write_reg
   task automatic read_reg(input logic [15:0] a, output logic [31:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask : read_reg
endmodule : irq_host_model
`default_nettype wire

// ==== verification/energy_event_irq_mask_zero_tb_top.sv ====
// testbench: event rows, reset values, gating and harmonic settling
`default_nettype none
module energy_event_irq_mask_zero_tb_top
   import irq_mask_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // stimulus word: energy bit 30, power sign, engine pulses, pulse levels
   localparam logic [31:0] BASE = 32'h0000_0007;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [15:0] addr;
   logic [31:0] wdata, rdata, got, m;
   logic [31:0] stim = BASE;
   logic        wr, rd, irq_n;
   logic [2:0]  pulse_n;
   int          errors = 0;
   int          total_checks = 0;
   int          cyc = 0;
   logic [63:0] rows [19] = '{
      64'h8000_0007_0000_0001,
      64'h0400_0007_0000_0002,
      64'h0100_0007_0000_0008,
      64'h0010_0007_0000_0010,
      64'h0000_0087_0000_0020,
      64'h0002_0007_0000_0040,
      64'h0004_0007_0000_0080,
      64'h0008_0007_0000_0100,
      64'h0000_0107_0000_0200,
      64'h0000_0807_0000_0400,
      64'h0000_1007_0000_0800,
      64'h0000_2007_0000_1000,
      64'h0000_0207_0000_2000,
      64'h0000_0006_0000_4000,
      64'h0000_0005_0000_8000,
      64'h0000_0003_0001_0000,
      64'h0000_0047_0002_0000,
      64'h0000_0407_0004_0000,
      64'h0000_000F_0000_8000};
   energy_event_irq_mask_zero #(.SETTLE_UNIT_CYCLES(4)) i_dut (
      .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .ENERGY_BIT30(stim[31:20]),
      .POWER_SIGN(stim[19:8]), .ENGINE_PULSE(stim[7:3]),
      .PULSE_LEVEL(stim[2:0]), .PULSE_OUTPUT_N(pulse_n),
      .PULSE_SOURCE_SELECT(), .HALF_LINE_CYCLES(), .HARMONIC_RATE(),
      .LINE_CYCLE_MODE(), .INTERRUPT_REQUEST_ONE_N(irq_n));
   irq_host_model i_host (
      .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // two stimulus cycles, then back to idle levels
   task automatic kick(input logic [31:0] v, input logic [31:0] w);
      stim <= v;
      @(posedge clk);
      stim <= w;
      @(posedge clk);
      stim <= BASE;
      repeat (4) @(posedge clk);
   endtask : kick
   task automatic expect_status(input logic [31:0] e);
      i_host.read_reg(EVENT_STATUS_ZERO_ADDR, got);
      chk(got, e);
   endtask : expect_status
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, irq_n}, 32'h0);
      expect_status(STATUS_RESET);
      i_host.read_reg(EVENT_INTERRUPT_ENABLE_ZERO_ADDR, got);
      chk(got, MASK_RESET);
      i_host.read_reg(16'h0000, got);
      chk(got, 32'h0000_0000);
      i_host.write_reg(EVENT_INTERRUPT_ENABLE_ZERO_ADDR, 32'hFFFF_FFFF);
      i_host.read_reg(EVENT_INTERRUPT_ENABLE_ZERO_ADDR, got);
      chk(got, MASK_STORED);
      i_host.write_reg(ACCUMULATION_MODE_ADDR, 32'h0000_0001);
      // pins disabled: pulse events must still be flagged
      i_host.write_reg(PULSE_OUTPUT_MODE_ADDR, 32'h0000_0E00);
      for (int p = 0; p < 2; p++) begin
         m = p ? MASK_STORED : 32'h0;
         i_host.write_reg(EVENT_INTERRUPT_ENABLE_ZERO_ADDR, m);
         foreach (rows[i]) begin
            kick(rows[i][63:32], BASE);
            chk({31'h0, irq_n}, {31'h0, !((|(rows[i][31:0] & m
               & MASK_EFFECT)) || rows[i][15])});
            expect_status(rows[i][31:0]);
            repeat (2) @(posedge clk);
            chk({31'h0, irq_n}, 32'h1);
         end
      end
      chk({29'h0, pulse_n}, 32'h7);
      // disabled pin stays high through a pulse, yet the flag is raised
      stim <= 32'h0000_0006;
      repeat (2) @(posedge clk);
      chk({29'h0, pulse_n}, 32'h7);
      stim <= BASE;
      @(posedge clk);
      expect_status(32'h0000_4000);
      i_host.write_reg(ACCUMULATION_MODE_ADDR, 32'h0000_0040);
      kick(32'h0000_0087, BASE);
      expect_status(32'h0);
      kick(32'h0000_4007, BASE);
      expect_status(32'h0000_0040);
      kick(32'h0002_0007, BASE);
      expect_status(32'h0);
      // update right after setup falls inside the settle time
      kick(32'h0000_0027, 32'h0000_0017);
      expect_status(32'h0);
      kick(32'h0000_0017, BASE);
      expect_status(32'h0008_0000);
      i_host.write_reg(HARMONIC_CONFIG_ADDR, 32'h0000_0002);
      kick(32'h0000_0027, 32'h0000_0017);
      expect_status(32'h0008_0000);
      end_sim();
   end
endmodule : energy_event_irq_mask_zero_tb_top
`default_nettype wire
